// ===== design/sar_host.sv
// Host end: runs slow-memory or ROM reads, delivers words through a buffer.
// Assumes one clock with the converter; user drains via valid/ready.
`default_nettype none
`include "sar_defs.svh"
module sar_host (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Converter link
	sar_if.host link,
	// User request
	input wire logic req_valid,
	input wire sar_pkg::sar_mode_e req_mode,
	input wire logic req_byte_wide,
	output logic req_ready,
	// User data out
	output logic data_valid,
	output sar_pkg::sar_code_t data_word,
	input wire logic data_ready
);
	typedef enum logic [2:0] {
		HST_IDLE,
		HST_STROBE,
		HST_WAIT,
		HST_SETTLE,
		HST_HIGH,
		HST_SPACE
	} sar_hst_state_e;

	// ==========================================
	// Host sequencer state
	sar_hst_state_e state_reg, state_next;
	sar_pkg::sar_mode_e mode_reg, mode_next;
	logic bytew_reg, bytew_next;
	logic sel_b_reg, sel_b_next;
	logic [15:0] cnt_reg, cnt_next;
	logic [`SAR_LO_BYTE_W-1:0] lo_reg, lo_next;
	logic [`SAR_HI_BYTE_W-1:0] hi_reg, hi_next;
	logic push;
	sar_pkg::sar_code_t push_word;
	logic buf_in_ready;

	// ==========================================
	// Two-entry buffer
	sar_pkg::sar_code_t mem_reg [`SAR_BUF_DEPTH];
	sar_pkg::sar_code_t mem_next [`SAR_BUF_DEPTH];
	logic wp_reg, wp_next, rp_reg, rp_next;
	logic [1:0] cnt_b_reg, cnt_b_next;
	logic pop;

	always_comb begin
		buf_in_ready = cnt_b_reg != 2'(`SAR_BUF_DEPTH);
		pop = data_ready && (cnt_b_reg != 2'h0);
		mem_next = mem_reg;
		wp_next = wp_reg;
		rp_next = rp_reg;
		cnt_b_next = cnt_b_reg;
		if (push && buf_in_ready) begin
			mem_next[wp_reg] = push_word;
			wp_next = !wp_reg;
		end
		if (pop)
			rp_next = !rp_reg;
		cnt_b_next = cnt_b_reg + {1'b0, push && buf_in_ready} - {1'b0, pop};
	end

	// ==========================================
	// Sequencer
	always_comb begin
		state_next = state_reg;
		mode_next = mode_reg;
		bytew_next = bytew_reg;
		sel_b_next = sel_b_reg;
		cnt_next = cnt_reg;
		lo_next = lo_reg;
		hi_next = hi_reg;
		push = 1'b0;
		push_word = {hi_reg, lo_reg};
		case (state_reg)
			HST_IDLE: begin
				// Stall new reads while buffer full so no word is lost
				if (req_valid && buf_in_ready && link.busy_b) begin
					mode_next = req_mode;
					bytew_next = req_byte_wide;
					sel_b_next = 1'b0;
					state_next = HST_STROBE;
				end
			end
			HST_STROBE: begin
				if (mode_reg == sar_pkg::SAR_MODE_ROM) begin
					// Bus enable trails the strobes by a clock; busy low shows it is on
					if (!link.busy_b) begin
						// Returns previous result
						push = 1'b1;
						push_word = link.result_bus;
						sel_b_next = 1'b1;
						cnt_next = `SAR_CONV_CLKS;
						state_next = HST_SPACE;
					end
				end else begin
					state_next = HST_WAIT;
				end
			end
			HST_WAIT: begin
				// Acknowledge withheld until busy high
				if (link.busy_b) begin
					cnt_next = 16'(`SAR_SETTLE_CLKS);
					state_next = HST_SETTLE;
				end
			end
			HST_SETTLE: begin
				if (cnt_reg == 16'h0000) begin
					lo_next = link.result_bus[`SAR_LO_BYTE_W-1:0];
					hi_next = link.result_bus[`SAR_MSB:`SAR_LO_BYTE_W];
					sel_b_next = 1'b1;
					if (bytew_reg) begin
						// High byte captured with the low byte; word pushed next cycle
						state_next = HST_HIGH;
					end else begin
						push = 1'b1;
						push_word = link.result_bus;
						state_next = HST_IDLE;
					end
				end else begin
					cnt_next = cnt_reg - 16'h0001;
				end
			end
			HST_HIGH: begin
				// No second bus read; word joined from both bytes captured in settle
				push = 1'b1;
				push_word = {hi_reg, lo_reg};
				state_next = HST_IDLE;
			end
			HST_SPACE: begin
				if (cnt_reg == 16'h0000)
					state_next = HST_IDLE;
				else
					cnt_next = cnt_reg - 16'h0001;
			end
			default: begin
				state_next = HST_IDLE;
				sel_b_next = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_reg <= HST_IDLE;
			mode_reg <= sar_pkg::SAR_MODE_SLOW;
			bytew_reg <= 1'b0;
			sel_b_reg <= 1'b1;
			cnt_reg <= 16'h0000;
			lo_reg <= 8'h00;
			hi_reg <= 4'h0;
			wp_reg <= 1'b0;
			rp_reg <= 1'b0;
			cnt_b_reg <= 2'h0;
			for (int i = 0; i < `SAR_BUF_DEPTH; i++)
				mem_reg[i] <= `SAR_ZERO12;
		end else begin
			state_reg <= state_next;
			mode_reg <= mode_next;
			bytew_reg <= bytew_next;
			sel_b_reg <= sel_b_next;
			cnt_reg <= cnt_next;
			lo_reg <= lo_next;
			hi_reg <= hi_next;
			wp_reg <= wp_next;
			rp_reg <= rp_next;
			cnt_b_reg <= cnt_b_next;
			mem_reg <= mem_next;
		end
	end

	// Select and read strobe tied together so both fall in one edge
	assign link.sel_b = sel_b_reg;
	assign link.rd_b = sel_b_reg;
	assign req_ready = (state_reg == HST_IDLE) && buf_in_ready && link.busy_b;
	assign data_valid = cnt_b_reg != 2'h0;
	assign data_word = mem_reg[rp_reg];
endmodule : sar_host
`default_nettype wire

// ===== design/sar_defs.svh
// Constants shared by both ends of the converter start and read port.
// Assumes inclusion by bare name from the design files.
`ifndef SAR_DEFS_SVH
`define SAR_DEFS_SVH
`define SAR_RES_W 12
`define SAR_MSB 11
`define SAR_LO_BYTE_W 8
`define SAR_HI_BYTE_W 4
`define SAR_ZERO12 12'h000
`define SAR_MID_CODE 12'h800
`define SAR_CODE_COUNT 4096
`define SAR_SPAN_MV 10000
`define SAR_PRE_CLKS 4'h1
`define SAR_CNT_W 4
`define SAR_BIT_IDX_RESET 4'hB
`define SAR_CONV_CLKS 16'h000D
`define SAR_SETTLE_CLKS 4'h2
`define SAR_BUF_DEPTH 2
`endif

// ===== design/sar_pkg.sv
// Types shared by both ends of the converter start and read port.
// Assumes sar_defs.svh is on the include path.
`default_nettype none
`include "sar_defs.svh"
package sar_pkg;
	typedef logic [`SAR_RES_W-1:0] sar_code_t;
	typedef enum logic {
		SAR_MODE_SLOW,
		SAR_MODE_ROM
	} sar_mode_e;
endpackage : sar_pkg
`default_nettype wire

// ===== design/sar_if.sv
// Link between converter and host: active-low strobes, busy, 12-bit bus.
// Assumes one clock shared by both ends; the interface resolves the bus.
`default_nettype none
`include "sar_defs.svh"
interface sar_if (
	input wire logic clk
);
	logic sel_b;
	logic rd_b;
	logic busy_b;
	sar_pkg::sar_code_t result_bus_out;
	logic result_bus_oe;
	sar_pkg::sar_code_t result_bus;
	assign result_bus = result_bus_oe ? result_bus_out : `SAR_ZERO12;
	modport conv (
		input clk, sel_b, rd_b,
		output busy_b, result_bus_out, result_bus_oe
	);
	modport host (
		input clk, busy_b, result_bus,
		output sel_b, rd_b
	);
endinterface : sar_if
`default_nettype wire

// ===== design/sar_conv.sv
// Converter end: start detect, approximation loop, result latch, bus drive.
// Assumes strobes synchronous to clk; comparator answer from analog model.
//
// Contract
// - Falling select and read together start conversion
// - Starts ignored while converting
// - Busy low throughout conversion
// - Previous result shown while converting and strobed
// - Latch updated before busy rises; here latch and busy change on the same edge
// - Slow host waits for completion
// - Host acknowledge withheld while busy low
// - ROM read starts and returns previous
// - Next ROM read returns new, restarts
// - ROM reads spaced one conversion apart
// - Host avoids reads during busy
// - Byte host reads low then high; here both bytes are captured in one cycle
// - Fast host captures on busy rise; this host has no fast mode and captures only after the settle count
// - Capture delayed after busy rise
// - Bipolar output offset binary, midscale split
// - Bipolar step is ten volts over 4096
// - Start clears register, enables outputs
// - Decisions MSB first, one per clock
// - Conversion length fixed in clocks
// - Unipolar natural binary, FS over 4096
`default_nettype none
`include "sar_defs.svh"
module sar_conv (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Host link
	sar_if.conv link,
	// Comparator: high keeps trial bit (input above DAC level)
	input wire logic cmp_keep,
	// Status
	output logic busy_b_out,
	output sar_pkg::sar_code_t result_out
);
	typedef enum logic [1:0] {
		SAR_IDLE,
		SAR_PRE,
		SAR_DECIDE,
		SAR_DONE
	} sar_state_e;

	// ==========================================
	// Declarations
	sar_state_e state_reg, state_next;
	logic [`SAR_CNT_W-1:0] idx_reg, idx_next;
	logic busy_b_reg, busy_b_next;
	logic strobe_reg, strobe_next;
	sar_pkg::sar_code_t approx_register_reg;
	wire sar_pkg::sar_code_t approx_register_next;
	sar_pkg::sar_code_t latch_reg, latch_next;
	logic oe_reg, oe_next;
	logic strobe_now;
	logic start;
	logic taking_start;
	logic settling;
	logic deciding;
	logic finishing;
	logic idx_zero;

	// ==========================================
	// Start detect
	// Edge, not level: strobes held past the end must not restart
	always_comb begin
		strobe_now = !link.sel_b && !link.rd_b;
		start = strobe_now && !strobe_reg;
		strobe_next = strobe_now;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			strobe_reg <= 1'b0;
		end else begin
			strobe_reg <= strobe_next;
		end
	end

	// ==========================================
	// State decodes
	always_comb begin
		taking_start = (state_reg == SAR_IDLE) && start;
		settling = state_reg == SAR_PRE;
		deciding = state_reg == SAR_DECIDE;
		finishing = state_reg == SAR_DONE;
		idx_zero = idx_reg == `SAR_CNT_W'(0);
	end

	// ==========================================
	// Sequencer: idle, settling gap, decisions, done
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			SAR_IDLE: begin
				// No queue: a start seen outside idle is simply lost
				if (taking_start) begin
					state_next = SAR_PRE;
				end
			end
			SAR_PRE: begin
				// Fixed gap before the MSB, as strobes are synchronous
				if (idx_zero) begin
					state_next = SAR_DECIDE;
				end
			end
			SAR_DECIDE: begin
				if (idx_zero) begin
					state_next = SAR_DONE;
				end
			end
			SAR_DONE: begin
				state_next = SAR_IDLE;
			end
			default: begin
				state_next = SAR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_reg <= SAR_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================
	// Bit index: gap count, then MSB down to LSB
	always_comb begin
		idx_next = idx_reg;
		if (taking_start) begin
			idx_next = `SAR_PRE_CLKS;
		end else if (settling && idx_zero) begin
			idx_next = `SAR_BIT_IDX_RESET;
		end else if ((settling || deciding) && !idx_zero) begin
			idx_next = idx_reg - `SAR_CNT_W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			idx_reg <= `SAR_PRE_CLKS;
		end else begin
			idx_reg <= idx_next;
		end
	end

	// ==========================================
	// Busy flag
	always_comb begin
		busy_b_next = busy_b_reg;
		if (taking_start) begin
			busy_b_next = 1'b0;
		end else if (finishing) begin
			busy_b_next = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			busy_b_reg <= 1'b1;
		end else begin
			busy_b_reg <= busy_b_next;
		end
	end

	// ==========================================
	// Approximation register, one trial bit each
	// Range wiring picks natural or offset binary; logic is alike
	for (genvar b = 0; b < `SAR_RES_W; b++) begin : g_trial
		assign approx_register_next[b] = taking_start ? 1'b0 :
			(deciding && idx_reg == `SAR_CNT_W'(b)) ? cmp_keep :
			approx_register_reg[b];
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			approx_register_reg <= `SAR_ZERO12;
		end else begin
			approx_register_reg <= approx_register_next;
		end
	end

	// ==========================================
	// Output latch
	// Old word stays all through a run, so the read that starts one
	// still returns the previous result
	always_comb begin
		latch_next = latch_reg;
		if (finishing) begin
			latch_next = approx_register_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			latch_reg <= `SAR_ZERO12;
		end else begin
			latch_reg <= latch_next;
		end
	end

	// ==========================================
	// Bus enable, one clock behind the strobes
	always_comb begin
		oe_next = strobe_now;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			oe_reg <= 1'b0;
		end else begin
			oe_reg <= oe_next;
		end
	end

	// ==========================================
	// Outputs
	assign link.result_bus_out = latch_reg;
	assign link.result_bus_oe = oe_reg;
	assign link.busy_b = busy_b_reg;
	assign busy_b_out = busy_b_reg;
	assign result_out = latch_reg;
endmodule : sar_conv
`default_nettype wire

// ===== test/sar_link_asserts.sv
// Checker: timing of the link between converter and host.
// Assumes instantiation beside the link interface, one clock domain.
`default_nettype none
module sar_link_asserts (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Link signals
	input wire logic sel_b,
	input wire logic rd_b,
	input wire logic busy_b,
	input wire sar_pkg::sar_code_t result_bus_out,
	input wire logic result_bus_oe
);
	// ==========================================================
	// Helpers
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	wire logic strb = !sel_b && !rd_b;
	// Split in two runs of seven, repetition counts stay small
	sequence s_low7;
		!busy_b [*7];
	endsequence
	sequence s_start;
		strb && !$past(strb) && busy_b;
	endsequence
	// ==========================================================
	// Properties
	AST_START: assert property (s_start |=> !busy_b)
		else $error("start edge did not raise busy");
	AST_BUSY_CAUSE: assert property ($fell(busy_b) |-> $past(strb))
		else $error("busy fell without a start");
	AST_BUSY_LEN: assert property ($fell(busy_b) |-> s_low7 ##1 s_low7 ##1 !busy_b ##1 busy_b)
		else $error("busy low time wrong");
	AST_NO_RESTART: assert property (($rose(busy_b) && strb) |=> busy_b)
		else $error("held strobes restarted");
	AST_OE_ON: assert property (strb |=> result_bus_oe)
		else $error("bus not driven under strobes");
	AST_OE_OFF: assert property (!strb |=> !result_bus_oe)
		else $error("bus driven without strobes");
	AST_LATCH_HOLD: assert property (!busy_b |-> $stable(result_bus_out))
		else $error("latch moved while converting");
	AST_LATCH_AT_DONE: assert property (!$stable(result_bus_out) |-> $rose(busy_b))
		else $error("latch moved away from done");
endmodule : sar_link_asserts
`default_nettype wire

// ===== test/sar_adc_start_and_read_port_tb_top.sv
// Bench: both link ends joined, user side driven and checked.
// Assumes design package, interface and both ends compiled first.
`default_nettype none
module sar_adc_start_and_read_port_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk;
	logic rst_b;
	logic cmp_keep;
	logic req_valid;
	sar_pkg::sar_mode_e req_mode;
	logic req_byte_wide;
	logic req_ready;
	logic data_valid;
	sar_pkg::sar_code_t data_word;
	logic data_ready;
	logic busy_b_out;
	sar_pkg::sar_code_t result_out;
	int miscompares;
	int check_count;
	// ==========================================================
	// Ends and checker
	sar_if link (.clk(clk));
	sar_conv i_sar_conv (.clk(clk), .rst_b(rst_b), .link(link), .cmp_keep(cmp_keep),
		.busy_b_out(busy_b_out), .result_out(result_out));
	sar_host i_sar_host (.clk(clk), .rst_b(rst_b), .link(link), .req_valid(req_valid),
		.req_mode(req_mode), .req_byte_wide(req_byte_wide), .req_ready(req_ready),
		.data_valid(data_valid), .data_word(data_word), .data_ready(data_ready));
	sar_link_asserts i_sar_link_asserts (.clk(clk), .rst_b(rst_b), .sel_b(link.sel_b),
		.rd_b(link.rd_b), .busy_b(link.busy_b), .result_bus_out(link.result_bus_out),
		.result_bus_oe(link.result_bus_oe));
	// ==========================================================
	// Tasks
	task automatic chk(input sar_pkg::sar_code_t got, input sar_pkg::sar_code_t exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic req(input sar_pkg::sar_mode_e m);
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		if (n >= 100) begin
			miscompares++;
			$display("FAIL %0t request never accepted", $time);
		end
		req_mode = m;
		req_valid = 1'b1;
		@(negedge clk);
		req_valid = 1'b0;
	endtask : req
	task automatic pop(input sar_pkg::sar_code_t exp);
		int n;
		n = 0;
		while (data_valid !== 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		if (n >= 200) begin
			miscompares++;
			$display("FAIL %0t no word delivered", $time);
		end
		chk(data_word, exp);
		data_ready = 1'b1;
		@(negedge clk);
		data_ready = 1'b0;
	endtask : pop
	task automatic t_slow();
		cmp_keep = 1'b1;
		req(sar_pkg::SAR_MODE_SLOW);
		pop(12'hFFF);
		chk(result_out, 12'hFFF);
		$display("slow read test done");
	endtask : t_slow
	// Buffer left undrained so the host must refuse a third word
	task automatic t_rom();
		cmp_keep = 1'b0;
		req(sar_pkg::SAR_MODE_ROM);
		req(sar_pkg::SAR_MODE_ROM);
		repeat (40) @(negedge clk);
		chk({11'h000, req_ready}, 12'h000);
		pop(12'hFFF);
		pop(12'h000);
		$display("rom read test done");
	endtask : t_rom
	// Alternating decisions, MSB first, word joined from two bytes of one read
	task automatic t_byte();
		req_byte_wide = 1'b1;
		req(sar_pkg::SAR_MODE_SLOW);
		req_byte_wide = 1'b0;
		for (int i = 0; i < 15; i++) begin
			cmp_keep = i[0];
			@(negedge clk);
		end
		pop(12'hAAA);
		$display("byte read test done");
	endtask : t_byte
	task automatic t_reset();
		cmp_keep = 1'b1;
		req(sar_pkg::SAR_MODE_SLOW);
		repeat (5) @(negedge clk);
		rst_b = 1'b0;
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		@(negedge clk);
		chk({11'h000, busy_b_out}, 12'h001);
		chk(result_out, 12'h000);
		req(sar_pkg::SAR_MODE_SLOW);
		pop(12'hFFF);
		$display("reset test done");
	endtask : t_reset
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : summarize
	// ==========================================================
	// Clock, watchdog, sequence
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Roughly seventeen times the expected run
	initial begin
		#20000;
		miscompares++;
		summarize();
	end
	initial begin
		miscompares = 0;
		check_count = 0;
		rst_b = 1'b0;
		cmp_keep = 1'b0;
		req_valid = 1'b0;
		req_mode = sar_pkg::SAR_MODE_SLOW;
		req_byte_wide = 1'b0;
		data_ready = 1'b0;
		repeat (6) @(negedge clk);
		rst_b = 1'b1;
		t_slow();
		t_rom();
		t_byte();
		t_reset();
		summarize();
	end
endmodule : sar_adc_start_and_read_port_tb_top
`default_nettype wire
